/* File: rtl/periph_irq_pkg.sv */
package periph_irq_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [3:0] OFF_ENABLE_ONE = 4'h0;
    localparam logic [3:0] OFF_ENABLE_TWO = 4'h1;
    localparam logic [3:0] OFF_FLAGS_ONE  = 4'h2;
    localparam logic [3:0] OFF_FLAGS_TWO  = 4'h3;
    localparam logic [3:0] OFF_CORE_CTRL  = 4'h4;
    localparam logic [3:0] OFF_EVT_STATUS = 4'h5;
    localparam logic [3:0] OFF_EVT_ENABLE = 4'h6;
    localparam logic [3:0] OFF_EVT_CLEAR  = 4'h7;

    localparam int unsigned BIT_ROLLOVER       = 0;
    localparam int unsigned BIT_PERIOD_MATCH   = 1;
    localparam int unsigned BIT_SERIAL_EVENT   = 4;
    localparam int unsigned BIT_BUS_COLLISION  = 5;
    localparam int unsigned BIT_CONV_DONE      = 6;
    localparam int unsigned BIT_INPUT_LOCKOUT  = 1;
    localparam int unsigned BIT_OUT_OVER_VOLT  = 4;
    localparam int unsigned BIT_OUT_OVER_CURR  = 5;
    localparam int unsigned BIT_OUT_UNDER_VOLT = 7;
    localparam int unsigned BIT_GROUP_ENABLE   = 6;
    localparam int unsigned BIT_GLOBAL_ENABLE  = 7;

    localparam int unsigned EVT_GROUP_REQ      = 0;
    localparam int unsigned EVT_STACK_OVER     = 1;
    localparam int unsigned EVT_STACK_UNDER    = 2;
    localparam int unsigned EVT_LOCKOUT_CHANGE = 3;

    localparam logic [7:0] MASK_ONE       = 8'h73;
    localparam logic [7:0] MASK_TWO       = 8'hb2;
    localparam logic [7:0] MASK_ERR_FLAGS = 8'hb0;
    localparam logic [7:0] MASK_CORE_CTRL = 8'hc0;
    localparam logic [7:0] MASK_EVT       = 8'h0f;
    localparam logic [7:0] RESET_REG      = 8'h00;

    localparam int unsigned PC_W         = 13;
    localparam int unsigned STACK_DEPTH  = 8;
    localparam int unsigned BANK_W       = 2;
    localparam int unsigned DADDR_W      = 7;
    localparam logic [6:0]  COMMON_BASE  = 7'h70;

endpackage

/* File: rtl/level_sync.sv */
`timescale 1ns/1ns
module level_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             MCLK,
    input  wire logic             RESET_N,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] stable_q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta_q  <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            meta_q  <= async_in;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
        end
    end

    // A bit moves only once two settled stages agree, which rejects single-cycle glitches.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge MCLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    stable_q[i] <= 1'b0;
                end else if (sync2_q[i] == sync3_q[i]) begin
                    stable_q[i] <= sync3_q[i];
                end
            end
        end
    endgenerate
endmodule

/* File: rtl/peripheral_interrupt_flags.sv */
`timescale 1ns/1ns
// Overview of operation
// - Second enable register holds four output/input enables.
// - Unimplemented register bits read zero, ignore writes.
// - Flags set on events regardless of enables.
// - Peripheral requests need group enable bit set.
// - Conversion done flag at bit six.
// - Collision bit five, serial event bit four.
// - Period match flag holds until software clears.
// - Rollover flag holds until software clears.
// - Output error flags at bits seven, five, four.
// - Bit one shows live input supply low.
// - Interrupt entry pushes only return address.
// - Top sixteen data bytes common to banks.
// - First enable register aligns with flag bits.
module peripheral_interrupt_flags
    import periph_irq_pkg::*;
#(
    parameter int unsigned DEPTH = STACK_DEPTH
) (
    input  wire logic               MCLK,
    input  wire logic               RESET_N,
    input  wire logic [ADDR_W-1:0]  ADDR,
    input  wire logic [DATA_W-1:0]  WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic      [DATA_W-1:0]  RDATA,
    input  wire logic               CONV_DONE,
    input  wire logic               BUS_COLLISION,
    input  wire logic               SERIAL_EVENT,
    input  wire logic               PERIOD_MATCH,
    input  wire logic               ROLLOVER,
    input  wire logic               OUT_UNDER_VOLTAGE,
    input  wire logic               OUT_OVER_CURRENT,
    input  wire logic               OUT_OVER_VOLTAGE,
    input  wire logic               INPUT_LOCKOUT,
    input  wire logic               IRQ_ENTRY,
    input  wire logic [PC_W-1:0]    ENTRY_PC,
    input  wire logic               IRQ_RETURN,
    output logic      [PC_W-1:0]    RETURN_PC,
    input  wire logic [BANK_W-1:0]  DMEM_BANK,
    input  wire logic [DADDR_W-1:0] DMEM_ADDR,
    output logic [BANK_W+DADDR_W-1:0] DMEM_PHYS,
    output logic                    PERIPH_REQ,
    output logic                    CORE_IRQ,
    output logic                    IRQ_OUT
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [7:0] enable_one_q;
    logic [7:0] enable_two_q;
    logic [7:0] flags_one_q;
    logic [7:0] flags_one_d;
    logic [7:0] flags_two_q;
    logic [7:0] flags_two_d;
    logic [7:0] core_ctrl_q;
    logic [7:0] evt_status_q;
    logic [7:0] evt_enable_q;
    logic [7:0] evt_set;
    logic [7:0] rdata_d;
    logic [7:0] events_one;
    logic [7:0] events_two;
    logic [3:0] analog_level;
    logic [3:0] analog_prev_q;
    logic       wr_enable_one;
    logic       wr_enable_two;
    logic       wr_flags_one;
    logic       wr_flags_two;
    logic       wr_core_ctrl;
    logic       wr_evt_enable;
    logic       wr_evt_clear;
    logic       request_d;
    logic       request_q;
    logic       push;
    logic       pop;
    logic [PC_W-1:0]  stack_mem [DEPTH];
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_below;
    logic [CNT_W-1:0] count_q;
    logic [PC_W-1:0]  return_pc_q;
    logic [BANK_W+DADDR_W-1:0] dmem_phys_q;
    logic [7:0]       rdata_q;
    logic             periph_req_q;
    logic             core_irq_q;
    logic             irq_out_q;

    // Analog comparator outputs arrive from outside the clock domain.
    level_sync #(
        .WIDTH (4)
    ) u_sync (
        .MCLK     (MCLK),
        .RESET_N  (RESET_N),
        .async_in ({OUT_UNDER_VOLTAGE, OUT_OVER_CURRENT, OUT_OVER_VOLTAGE, INPUT_LOCKOUT}),
        .stable_q (analog_level)
    );

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            analog_prev_q <= 4'h0;
        end else begin
            analog_prev_q <= analog_level;
        end
    end

    assign wr_enable_one = WR && (ADDR == OFF_ENABLE_ONE);
    assign wr_enable_two = WR && (ADDR == OFF_ENABLE_TWO);
    assign wr_flags_one  = WR && (ADDR == OFF_FLAGS_ONE);
    assign wr_flags_two  = WR && (ADDR == OFF_FLAGS_TWO);
    assign wr_core_ctrl  = WR && (ADDR == OFF_CORE_CTRL);
    assign wr_evt_enable = WR && (ADDR == OFF_EVT_ENABLE);
    assign wr_evt_clear  = WR && (ADDR == OFF_EVT_CLEAR);

    // Event vectors placed at their flag positions so enables line up bit for bit.
    always_comb begin
        events_one = 8'h00;
        events_one[BIT_CONV_DONE]     = CONV_DONE;
        events_one[BIT_BUS_COLLISION] = BUS_COLLISION;
        events_one[BIT_SERIAL_EVENT]  = SERIAL_EVENT;
        events_one[BIT_PERIOD_MATCH]  = PERIOD_MATCH;
        events_one[BIT_ROLLOVER]      = ROLLOVER;
    end

    // Output errors are caught on the rising edge of the settled comparator level.
    always_comb begin
        events_two = 8'h00;
        events_two[BIT_OUT_UNDER_VOLT] = analog_level[3] && !analog_prev_q[3];
        events_two[BIT_OUT_OVER_CURR]  = analog_level[2] && !analog_prev_q[2];
        events_two[BIT_OUT_OVER_VOLT]  = analog_level[1] && !analog_prev_q[1];
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_one_q <= RESET_REG;
        end else if (wr_enable_one) begin
            enable_one_q <= WDATA & MASK_ONE;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_two_q <= RESET_REG;
        end else if (wr_enable_two) begin
            enable_two_q <= WDATA & MASK_TWO;
        end
    end

    // Software may write any implemented flag; a same-cycle event still sets it.
    always_comb begin
        flags_one_d = flags_one_q;
        if (wr_flags_one) begin
            flags_one_d = WDATA & MASK_ONE;
        end
        flags_one_d = flags_one_d | (events_one & MASK_ONE);
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_one_q <= RESET_REG;
        end else begin
            flags_one_q <= flags_one_d;
        end
    end

    // The supply status bit is a live level, so writes to it have no effect.
    always_comb begin
        flags_two_d = flags_two_q & MASK_ERR_FLAGS;
        if (wr_flags_two) begin
            flags_two_d = WDATA & MASK_ERR_FLAGS;
        end
        flags_two_d = flags_two_d | (events_two & MASK_ERR_FLAGS);
        flags_two_d[BIT_INPUT_LOCKOUT] = analog_level[0];
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_two_q <= RESET_REG;
        end else begin
            flags_two_q <= flags_two_d;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            core_ctrl_q <= RESET_REG;
        end else if (wr_core_ctrl) begin
            core_ctrl_q <= WDATA & MASK_CORE_CTRL;
        end
    end

    // Enabling a source with a stale flag pending raises the request at once.
    assign request_d = |((flags_one_q & enable_one_q) | (flags_two_q & enable_two_q));

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            request_q    <= 1'b0;
            periph_req_q <= 1'b0;
            core_irq_q   <= 1'b0;
        end else begin
            request_q    <= request_d;
            periph_req_q <= request_d && core_ctrl_q[BIT_GROUP_ENABLE];
            core_irq_q   <= request_d && core_ctrl_q[BIT_GROUP_ENABLE]
                            && core_ctrl_q[BIT_GLOBAL_ENABLE];
        end
    end

    // A push and a pop in the same cycle resolve as a push; the pop is dropped.
    assign push      = IRQ_ENTRY;
    assign pop       = IRQ_RETURN && !IRQ_ENTRY;
    assign ptr_below = ptr_q - PTR_W'(1);

    // Only the return address is saved; working and status registers stay with software.
    always_ff @(posedge MCLK) begin
        if (push) begin
            stack_mem[ptr_q] <= ENTRY_PC;
        end
    end

    // The stack wraps like a ring, so an overflow overwrites the oldest entry.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr_q   <= '0;
            count_q <= '0;
        end else if (push) begin
            ptr_q   <= (ptr_q == PTR_LAST) ? '0 : ptr_q + PTR_W'(1);
            if (count_q != CNT_FULL) begin
                count_q <= count_q + CNT_W'(1);
            end
        end else if (pop) begin
            ptr_q   <= (ptr_q == '0) ? PTR_LAST : ptr_below;
            if (count_q != '0) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            return_pc_q <= '0;
        end else if (pop) begin
            return_pc_q <= stack_mem[(ptr_q == '0) ? PTR_LAST : ptr_below];
        end
    end

    // The top sixteen locations of each bank fold onto bank zero's copy.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dmem_phys_q <= '0;
        end else if (DMEM_ADDR >= COMMON_BASE) begin
            dmem_phys_q <= {{BANK_W{1'b0}}, DMEM_ADDR};
        end else begin
            dmem_phys_q <= {DMEM_BANK, DMEM_ADDR};
        end
    end

    always_comb begin
        evt_set = 8'h00;
        evt_set[EVT_GROUP_REQ]      = request_d && !request_q;
        evt_set[EVT_STACK_OVER]     = push && (count_q == CNT_FULL);
        evt_set[EVT_STACK_UNDER]    = IRQ_RETURN && !IRQ_ENTRY && (count_q == '0);
        evt_set[EVT_LOCKOUT_CHANGE] = analog_level[0] != analog_prev_q[0];
    end

    // Clear is write-one-to-clear; a new event in the same cycle wins.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            evt_status_q <= RESET_REG;
        end else if (wr_evt_clear) begin
            evt_status_q <= ((evt_status_q & ~WDATA) | evt_set) & MASK_EVT;
        end else begin
            evt_status_q <= (evt_status_q | evt_set) & MASK_EVT;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            evt_enable_q <= RESET_REG;
        end else if (wr_evt_enable) begin
            evt_enable_q <= WDATA & MASK_EVT;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_out_q <= 1'b0;
        end else begin
            irq_out_q <= |(evt_status_q & evt_enable_q);
        end
    end

    // Unmapped addresses and the write-only clear register read as zero.
    always_comb begin
        rdata_d = 8'h00;
        unique case (ADDR)
            OFF_ENABLE_ONE: rdata_d = enable_one_q;
            OFF_ENABLE_TWO: rdata_d = enable_two_q;
            OFF_FLAGS_ONE:  rdata_d = flags_one_q;
            OFF_FLAGS_TWO:  rdata_d = flags_two_q;
            OFF_CORE_CTRL:  rdata_d = core_ctrl_q;
            OFF_EVT_STATUS: rdata_d = evt_status_q;
            OFF_EVT_ENABLE: rdata_d = evt_enable_q;
            default:        rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= 8'h00;
        end else if (RD) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA      = rdata_q;
    assign RETURN_PC  = return_pc_q;
    assign DMEM_PHYS  = dmem_phys_q;
    assign PERIPH_REQ = periph_req_q;
    assign CORE_IRQ   = core_irq_q;
    assign IRQ_OUT    = irq_out_q;
endmodule

/* File: verification/pif_chk.sv */
`timescale 1ns/1ns
module pif_chk
    import periph_irq_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              RESET_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic              ROLLOVER,
    input wire logic              INPUT_LOCKOUT,
    input wire logic              PERIPH_REQ,
    input wire logic              CORE_IRQ,
    input wire logic              IRQ_OUT
);
    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    sequence rd_at(logic [3:0] a);
        RD && ADDR == a;
    endsequence
    // The idle cycle keeps a software clear from landing between event and read.
    sequence roll_then_rd;
        ROLLOVER ##1 !WR ##1 rd_at(OFF_FLAGS_ONE);
    endsequence
    sequence lockout_held;
        INPUT_LOCKOUT [*8] ##0 rd_at(OFF_FLAGS_TWO);
    endsequence
    en_one_bits_a: assert property (
        rd_at(OFF_ENABLE_ONE) |=> (RDATA & ~MASK_ONE) == 8'h00) else $error("enable one bits");
    en_two_bits_a: assert property (
        rd_at(OFF_ENABLE_TWO) |=> (RDATA & ~MASK_TWO) == 8'h00) else $error("enable two bits");
    flag_one_bits_a: assert property (
        rd_at(OFF_FLAGS_ONE) |=> (RDATA & ~MASK_ONE) == 8'h00) else $error("flags one bits");
    flag_two_bits_a: assert property (
        rd_at(OFF_FLAGS_TWO) |=> (RDATA & ~MASK_TWO) == 8'h00) else $error("flags two bits");
    unmapped_zero_a: assert property (
        RD && ADDR[3] |=> RDATA == 8'h00) else $error("unmapped read not zero");
    rollover_held_a: assert property (
        roll_then_rd |=> RDATA[BIT_ROLLOVER]) else $error("rollover flag lost");
    lockout_live_a: assert property (
        lockout_held |=> RDATA[BIT_INPUT_LOCKOUT]) else $error("lockout status low");
    core_group_a: assert property (
        CORE_IRQ |-> PERIPH_REQ) else $error("core irq without group request");
    reset_quiet_a: assert property (
        $rose(RESET_N) |-> !(PERIPH_REQ || CORE_IRQ || IRQ_OUT)) else $error("output after reset");
endmodule

bind peripheral_interrupt_flags pif_chk chk_u (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WR(WR), .RD(RD), .RDATA(RDATA), .ROLLOVER(ROLLOVER), .INPUT_LOCKOUT(INPUT_LOCKOUT),
    .PERIPH_REQ(PERIPH_REQ), .CORE_IRQ(CORE_IRQ), .IRQ_OUT(IRQ_OUT));

/* File: verification/event_src.sv */
`timescale 1ns/1ns
module event_src (
    input  wire logic       MCLK,
    output logic      [4:0] pulse,
    output logic      [3:0] level
);
    initial begin
        pulse = 5'h00;
        level = 4'h0;
    end
    // Timers, converter and serial port pulse for exactly one clock.
    always @(posedge MCLK) begin
        if (pulse != 5'h00) begin
            pulse <= 5'h00;
        end
    end
    task automatic arm(input logic [4:0] v);
        pulse <= v;
    endtask
    // Comparators are unclocked, so their levels move between edges.
    task automatic set_level(input logic [3:0] v);
        #3 level = v;
    endtask
endmodule

/* File: verification/peripheral_interrupt_flags_tb.sv */
`timescale 1ns/1ns
module peripheral_interrupt_flags_tb
    import periph_irq_pkg::*;
;
    logic        mclk;
    logic        reset_n;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [4:0]  pulse;
    logic [3:0]  level;
    logic        irq_entry;
    logic [12:0] entry_pc;
    logic        irq_return;
    logic [12:0] return_pc;
    logic [1:0]  bank;
    logic [6:0]  daddr;
    logic [8:0]  phys;
    logic        periph_req;
    logic        core_irq;
    logic        irq_out;
    logic [7:0]  m [8];
    logic        lk;
    logic        pr;
    logic [3:0]  fr;
    logic [7:0]  d;
    logic [12:0] p;
    logic [12:0] pc [$];
    int          n_mismatch;
    int          num_checks;
    int          a;
    int unsigned seed = 89;
    int          rb [8] = '{0, 1, 4, 5, 6, 4, 5, 7};

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    event_src src_u (.MCLK(mclk), .pulse(pulse), .level(level));

    peripheral_interrupt_flags dut_u (.MCLK(mclk), .RESET_N(reset_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CONV_DONE(pulse[4]),
        .BUS_COLLISION(pulse[3]), .SERIAL_EVENT(pulse[2]), .PERIOD_MATCH(pulse[1]),
        .ROLLOVER(pulse[0]), .OUT_UNDER_VOLTAGE(level[3]), .OUT_OVER_CURRENT(level[2]),
        .OUT_OVER_VOLTAGE(level[1]), .INPUT_LOCKOUT(level[0]), .IRQ_ENTRY(irq_entry),
        .ENTRY_PC(entry_pc), .IRQ_RETURN(irq_return), .RETURN_PC(return_pc),
        .DMEM_BANK(bank), .DMEM_ADDR(daddr), .DMEM_PHYS(phys), .PERIPH_REQ(periph_req),
        .CORE_IRQ(core_irq), .IRQ_OUT(irq_out));

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [3:0] x);
        if (x[3] || x == OFF_EVT_CLEAR) return 8'h00;
        if (x == OFF_FLAGS_TWO) return m[3] | {6'h00, lk, 1'b0};
        return m[x[2:0]];
    endfunction

    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The idle edge after each strobe keeps a strobe from being set twice in one step.
    task automatic bw(input logic [3:0] x, input logic [7:0] v);
        addr <= x;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        case (x)
            OFF_ENABLE_ONE, OFF_FLAGS_ONE: m[x[2:0]] = v & MASK_ONE;
            OFF_ENABLE_TWO: m[1] = v & MASK_TWO;
            OFF_FLAGS_TWO: m[3] = v & MASK_ERR_FLAGS;
            OFF_CORE_CTRL: m[4] = v & MASK_CORE_CTRL;
            OFF_EVT_ENABLE: m[6] = v & MASK_EVT;
            OFF_EVT_CLEAR: m[5] = m[5] & ~v;
            default: ;
        endcase
        @(posedge mclk);
    endtask

    task automatic br(input logic [3:0] x);
        addr <= x;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(13'(rdata), 13'(exp_rd(x)));
        @(posedge mclk);
    endtask

    task automatic outs();
        logic q;
        logic r;
        q = (m[0] & m[2]) != 8'h00 || (m[1] & m[3]) != 8'h00 || (lk && m[1][1]);
        r = q && m[4][BIT_GROUP_ENABLE];
        // The status bit follows the raw request, before the group enable gates it.
        if (q && !pr) m[5][EVT_GROUP_REQ] = 1'b1;
        pr = q;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(13'(periph_req), 13'(r));
        chk(13'(core_irq), 13'(r && m[4][BIT_GLOBAL_ENABLE]));
        chk(13'(irq_out), 13'((m[5] & m[6]) != 8'h00));
        @(posedge mclk);
    endtask

    task automatic ev(input int i);
        if (i < 5) begin
            src_u.arm(5'h01 << i);
            @(posedge mclk);
        end else begin
            src_u.set_level(4'h1 << (i - 4));
            repeat (8) @(posedge mclk);
            src_u.set_level(4'h0);
        end
        m[(i < 5) ? 2 : 3][rb[i]] = 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        irq_entry = 1'b0;
        entry_pc = 13'h0000;
        irq_return = 1'b0;
        bank = 2'h0;
        daddr = 7'h00;
        n_mismatch = 0;
        num_checks = 0;
        lk = 1'b0;
        pr = 1'b0;
        foreach (m[k]) m[k] = RESET_REG;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (a = 0; a < 16; a++) br(a[3:0]);
        repeat (16) begin
            a = xs() % 16;
            d = 8'(xs());
            if (a != 7) bw(a[3:0], d);
            if (a != 5) br(a[3:0]);
        end
        for (a = 0; a < 7; a++) bw(a[3:0], 8'h00);
        bw(OFF_EVT_CLEAR, MASK_EVT);
        outs();
        for (a = 0; a < 8; a++) begin
            fr = (a < 5) ? OFF_FLAGS_ONE : OFF_FLAGS_TWO;
            bw(OFF_CORE_CTRL, 8'h40);
            ev(a);
            br(fr);
            outs();
            bw(fr, 8'h00);
            bw(fr - 4'h2, 8'h01 << rb[a]);
            ev(a);
            outs();
            bw(OFF_CORE_CTRL, 8'h80);
            outs();
            bw(OFF_CORE_CTRL, 8'hc0);
            outs();
            bw(fr, 8'h00);
            bw(fr - 4'h2, 8'h00);
            outs();
        end
        src_u.arm(5'h01);
        bw(OFF_FLAGS_ONE, 8'h00);
        m[2][BIT_ROLLOVER] = 1'b1;
        br(OFF_FLAGS_ONE);
        bw(OFF_EVT_ENABLE, 8'h01);
        outs();
        br(OFF_EVT_STATUS);
        bw(OFF_EVT_ENABLE, 8'h00);
        outs();
        bw(OFF_EVT_ENABLE, MASK_EVT);
        bw(OFF_EVT_CLEAR, 8'h01);
        outs();
        lk = 1'b1;
        src_u.set_level(4'h1);
        repeat (8) @(posedge mclk);
        m[5][EVT_LOCKOUT_CHANGE] = 1'b1;
        outs();
        br(OFF_FLAGS_TWO);
        lk = 1'b0;
        src_u.set_level(4'h0);
        repeat (8) @(posedge mclk);
        br(OFF_FLAGS_TWO);
        irq_entry <= 1'b1;
        repeat (3) begin
            p = 13'(xs());
            entry_pc <= p;
            pc.push_back(p);
            @(posedge mclk);
        end
        irq_entry <= 1'b0;
        irq_return <= 1'b1;
        for (a = 0; a < 3; a++) begin
            @(posedge mclk);
            if (a == 2) irq_return <= 1'b0;
            @(negedge mclk);
            chk(return_pc, pc.pop_back());
        end
        // A pop on the empty stack, then one push more than it holds.
        @(posedge mclk);
        irq_return <= 1'b1;
        @(posedge mclk);
        irq_return <= 1'b0;
        irq_entry <= 1'b1;
        repeat (STACK_DEPTH + 1) @(posedge mclk);
        irq_entry <= 1'b0;
        m[5][EVT_STACK_UNDER] = 1'b1;
        m[5][EVT_STACK_OVER] = 1'b1;
        br(OFF_EVT_STATUS);
        repeat (8) begin
            @(posedge mclk);
            p = 13'(xs());
            bank <= p[8:7];
            daddr <= p[6:0];
            @(posedge mclk);
            @(negedge mclk);
            chk(13'(phys), 13'((p[6:0] >= COMMON_BASE) ? {2'b00, p[6:0]} : p[8:0]));
        end
        test_done();
    end
endmodule
